// ==== design/drc_ahb.sv ====
module drc_ahb (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register access
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data
);
    typedef struct packed {
        logic wpend;
        logic [11:0] waddr;
        logic [31:0] rdata;
    } drc_ahb_st_t;

    drc_ahb_st_t st_r;
    drc_ahb_st_t st_nxt;
    logic take;

    assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

    always_comb begin
        st_nxt = st_r;
        st_nxt.wpend = take && hwrite;
        if (take) begin
            st_nxt.waddr = haddr[11:0];
        end
        if (take && !hwrite) begin
            st_nxt.rdata = rd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_addr = haddr[11:0];
    assign wr_en = st_r.wpend;
    assign wr_addr = st_r.waddr;
    assign wr_data = hwdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
endmodule

// ==== design/drc_pkg.sv ====
package drc_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_APP_CAUSE = 12'h000;
    localparam logic [11:0] OFS_NET_CAUSE = 12'h004;
    localparam logic [11:0] OFS_NET_HOLD = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;

    // cause bit positions (both cause registers)
    localparam int CB_PIN = 0;
    localparam int CB_WDOG = 1;
    localparam int CB_SOFT = 2;
    localparam int CB_LOCKUP = 3;
    localparam int CB_OFFWAKE = 4;
    localparam int CB_BROWN = 5;
    localparam int CB_APPWDOG = 6;
    localparam int CB_HOLDOFF = 7;
    localparam int CB_DBGSOFT = 8;
    localparam int CAUSE_W = 9;

    // status bit positions
    localparam int SB_APP_RUN = 0;
    localparam int SB_NET_RUN = 1;
    localparam int SB_DBG_MODE = 2;
    localparam int SB_SYS_RST = 3;

    localparam logic [CAUSE_W-1:0] CAUSE_RST = 9'h000;
    localparam logic NET_HOLD_RST = 1'b1;

    // cycles each core reset pulse lasts
    localparam logic [3:0] CORE_RST_CYC = 4'h4;

    typedef enum logic [1:0] {
        DRC_SYS_HOLD = 2'b00,
        DRC_CORE_RST = 2'b01,
        DRC_RUN = 2'b10
    } drc_state_t;

    // asynchronous indications from the power and pin world
    typedef struct packed {
        logic supply_good;
        logic regulator_started;
        logic brownout_reset;
        logic reset_pin_n;
        logic offwake;
    } drc_sys_in_t;

    // per-core event pulses, same clock
    typedef struct packed {
        logic core_sys_reset_request;
        logic lockup;
        logic watchdog_timer;
        logic dbg_soft;
    } drc_core_ev_t;

    typedef struct packed {
        logic cpu_rst;
        logic wdog_rst;
        logic periph_rst;
        logic run;
    } drc_core_out_t;

endpackage

// ==== design/drc_sync.sv ====
module drc_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } drc_sync_st_t;

    drc_sync_st_t st_r;
    drc_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// ==== design/drc_top.sv ====
// What this block does
// - power-on, brownout or reset pin resets both cores
// - soft reset or lockup resets its own core; from application core it also holds network core
// - after system reset application core runs, network core stays stopped
// - each core has its own reset cause register
// - network cause register also flags system and application sources
// - hold system in reset until supply good and regulator started
// - reset pin resets system; application core starts when pin released
// - brownout holds system reset; application restarts when it ends
// - wakeup from system off resets device; application core starts
// - in debug mode offwake leaves debug access port out of reset
// - core system reset request bit causes soft reset of that core
// - application soft reset holds network core; network soft reset is local
// - debugger write of control port reset register causes soft reset
// - each core has its own watchdog reset aimed at that core
// - application watchdog holds network core; network watchdog is local
// - application writes hold register to hold or release network core
// - every application reset sets network hold until software clears it
// - hold-off caused by application reset is a distinct network cause
// - in debug mode debug parts stay except on application watchdog reset, and lockup causes no reset
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
module drc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power and pin indications, asynchronous
    input wire drc_pkg::drc_sys_in_t sys_in,
    input wire logic debug_mode,
    // core events
    input wire drc_pkg::drc_core_ev_t app_ev,
    input wire drc_pkg::drc_core_ev_t net_ev,
    // reset outputs
    output drc_pkg::drc_core_out_t app_out,
    output drc_pkg::drc_core_out_t net_out,
    output logic debug_access_port_rst
);
    localparam int CW = drc_pkg::CAUSE_W;
    // reset pin is carried inverted through the synchroniser so its cleared state means released
    localparam logic [4:0] SYS_IN_FLIP = 5'h02;

    typedef struct packed {
        drc_pkg::drc_state_t state;
        logic [3:0] cnt;
        logic offwake_d;
        logic [CW-1:0] app_cause;
        logic [CW-1:0] net_cause;
        logic net_hold;
        logic app_rst;
        logic net_rst;
        logic net_wd;
        logic dbg_rst;
        logic [3:0] net_cnt;
    } drc_st_t;

    drc_st_t st_r;
    drc_st_t st_nxt;

    logic [4:0] sys_q;
    logic [CW-1:0] sys_vec;
    logic dbg_q;
    logic sys_hold;
    logic offwake_ev;
    logic app_soft;
    logic app_lock;
    logic net_soft;
    logic net_lock;
    logic app_any;
    logic net_any;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;

    function automatic logic [CW-1:0] cause_bit(input int pos);
        logic [CW-1:0] v;
        v = '0;
        v[pos] = 1'b1;
        return v;
    endfunction

    // sticky flags with write-one-to-clear, set wins over clear
    function automatic logic [CW-1:0] w1c(input logic [CW-1:0] cur, input logic [CW-1:0] set,
                                          input logic clr, input logic [CW-1:0] mask);
        logic [CW-1:0] v;
        v = clr ? (cur & ~mask) : cur;
        return v | set;
    endfunction

    drc_sync #(
        .W(6)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d({debug_mode, sys_in ^ SYS_IN_FLIP}),
        .q({dbg_q, sys_q})
    );

    drc_ahb u_ahb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    drc_pkg::drc_sys_in_t sq;
    assign sq = sys_q ^ SYS_IN_FLIP;

    // system hold: supply not ready, brownout, pin low
    assign sys_hold = !sq.supply_good || !sq.regulator_started || sq.brownout_reset || !sq.reset_pin_n;
    assign offwake_ev = sq.offwake && !st_r.offwake_d;
    assign app_soft = app_ev.core_sys_reset_request || app_ev.dbg_soft;
    assign net_soft = net_ev.core_sys_reset_request || net_ev.dbg_soft;
    assign app_lock = app_ev.lockup && !dbg_q;
    assign net_lock = net_ev.lockup && !dbg_q;
    assign app_any = app_soft || app_lock || app_ev.watchdog_timer || offwake_ev;
    assign net_any = net_soft || net_lock || net_ev.watchdog_timer;

    always_comb begin
        sys_vec = '0;
        if (!sq.reset_pin_n) begin
            sys_vec = sys_vec | cause_bit(drc_pkg::CB_PIN);
        end
        if (sq.brownout_reset) begin
            sys_vec = sys_vec | cause_bit(drc_pkg::CB_BROWN);
        end
    end

    always_comb begin
        logic [CW-1:0] aset;
        logic [CW-1:0] nset;
        logic wa;
        logic wn;
        aset = '0;
        nset = '0;
        st_nxt = st_r;
        st_nxt.offwake_d = sq.offwake;
        wa = wr_en && (wr_addr == drc_pkg::OFS_APP_CAUSE);
        wn = wr_en && (wr_addr == drc_pkg::OFS_NET_CAUSE);
        if (wr_en && (wr_addr == drc_pkg::OFS_NET_HOLD)) begin
            st_nxt.net_hold = wr_data[0];
        end
        unique case (st_r.state)
            drc_pkg::DRC_SYS_HOLD: begin
                st_nxt.app_rst = 1'b1;
                st_nxt.net_rst = 1'b1;
                st_nxt.dbg_rst = 1'b1;
                st_nxt.net_hold = 1'b1;
                aset = sys_vec;
                nset = sys_vec;
                if (!sys_hold) begin
                    st_nxt.state = drc_pkg::DRC_RUN;
                    st_nxt.app_rst = 1'b0;
                    st_nxt.net_rst = 1'b0;
                    st_nxt.dbg_rst = 1'b0;
                end
            end
            drc_pkg::DRC_CORE_RST: begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1) begin
                    st_nxt.state = drc_pkg::DRC_RUN;
                    st_nxt.app_rst = 1'b0;
                    st_nxt.dbg_rst = 1'b0;
                end
                if (sys_hold) begin
                    st_nxt.state = drc_pkg::DRC_SYS_HOLD;
                end
            end
            drc_pkg::DRC_RUN: begin
                if (sys_hold) begin
                    st_nxt.state = drc_pkg::DRC_SYS_HOLD;
                    st_nxt.app_rst = 1'b1;
                    st_nxt.net_rst = 1'b1;
                    st_nxt.dbg_rst = 1'b1;
                end else if (app_any) begin
                    st_nxt.state = drc_pkg::DRC_CORE_RST;
                    st_nxt.cnt = drc_pkg::CORE_RST_CYC;
                    st_nxt.app_rst = 1'b1;
                    st_nxt.net_hold = 1'b1;
                    st_nxt.dbg_rst = (offwake_ev && !dbg_q) || app_ev.watchdog_timer;
                    if (app_soft) begin
                        aset = aset | cause_bit(drc_pkg::CB_SOFT);
                        nset = nset | cause_bit(drc_pkg::CB_SOFT);
                    end
                    if (app_lock) begin
                        aset = aset | cause_bit(drc_pkg::CB_LOCKUP);
                        nset = nset | cause_bit(drc_pkg::CB_LOCKUP);
                    end
                    if (app_ev.watchdog_timer) begin
                        aset = aset | cause_bit(drc_pkg::CB_WDOG);
                        nset = nset | cause_bit(drc_pkg::CB_APPWDOG);
                    end
                    if (offwake_ev) begin
                        aset = aset | cause_bit(drc_pkg::CB_OFFWAKE);
                        nset = nset | cause_bit(drc_pkg::CB_OFFWAKE);
                    end
                    if (app_ev.dbg_soft) begin
                        aset = aset | cause_bit(drc_pkg::CB_DBGSOFT);
                    end
                    nset = nset | cause_bit(drc_pkg::CB_HOLDOFF);
                end
            end
            default: begin
                st_nxt.state = drc_pkg::DRC_SYS_HOLD;
            end
        endcase
        // network core local reset pulse, only when app core not forcing
        if (st_r.net_cnt != 4'h0) begin
            st_nxt.net_cnt = st_r.net_cnt - 4'h1;
            if (st_r.net_cnt == 4'h1) begin
                st_nxt.net_wd = 1'b0;
            end
        end else if (net_any && st_r.state == drc_pkg::DRC_RUN && !st_r.net_hold) begin
            st_nxt.net_cnt = drc_pkg::CORE_RST_CYC;
            st_nxt.net_wd = net_ev.watchdog_timer;
            if (net_soft) begin
                nset = nset | cause_bit(drc_pkg::CB_SOFT);
            end
            if (net_lock) begin
                nset = nset | cause_bit(drc_pkg::CB_LOCKUP);
            end
            if (net_ev.watchdog_timer) begin
                nset = nset | cause_bit(drc_pkg::CB_WDOG);
            end
            if (net_ev.dbg_soft) begin
                nset = nset | cause_bit(drc_pkg::CB_DBGSOFT);
            end
        end
        st_nxt.app_cause = w1c(st_r.app_cause, aset, wa, wr_data[CW-1:0]);
        st_nxt.net_cause = w1c(st_r.net_cause, nset, wn, wr_data[CW-1:0]);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r.state <= drc_pkg::DRC_SYS_HOLD;
            st_r.cnt <= 4'h0;
            st_r.offwake_d <= 1'b0;
            st_r.app_cause <= drc_pkg::CAUSE_RST;
            st_r.net_cause <= drc_pkg::CAUSE_RST;
            st_r.net_hold <= drc_pkg::NET_HOLD_RST;
            st_r.app_rst <= 1'b1;
            st_r.net_rst <= 1'b1;
            st_r.net_wd <= 1'b0;
            st_r.dbg_rst <= 1'b1;
            st_r.net_cnt <= 4'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            drc_pkg::OFS_APP_CAUSE: rd_data[CW-1:0] = st_r.app_cause;
            drc_pkg::OFS_NET_CAUSE: rd_data[CW-1:0] = st_r.net_cause;
            drc_pkg::OFS_NET_HOLD: rd_data[0] = st_r.net_hold;
            drc_pkg::OFS_STATUS: begin
                rd_data[drc_pkg::SB_APP_RUN] = !st_r.app_rst;
                rd_data[drc_pkg::SB_NET_RUN] = net_out.run;
                rd_data[drc_pkg::SB_DBG_MODE] = dbg_q;
                rd_data[drc_pkg::SB_SYS_RST] = (st_r.state == drc_pkg::DRC_SYS_HOLD);
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // core outputs
    assign app_out.cpu_rst = st_r.app_rst;
    assign app_out.wdog_rst = st_r.app_rst && (st_r.state == drc_pkg::DRC_SYS_HOLD || st_r.dbg_rst);
    assign app_out.periph_rst = st_r.app_rst;
    assign app_out.run = !st_r.app_rst;
    assign net_out.cpu_rst = st_r.net_rst || st_r.net_hold || (st_r.net_cnt != 4'h0);
    assign net_out.wdog_rst = st_r.net_rst || st_r.net_hold || st_r.net_wd;
    assign net_out.periph_rst = net_out.cpu_rst;
    assign net_out.run = !net_out.cpu_rst;
    assign debug_access_port_rst = st_r.dbg_rst;
endmodule

// ==== verification/drc_core_model.sv ====
module drc_core_model (
    // clock
    input wire logic sys_clk,
    // commands from the bench
    input wire logic [3:0] fire_app,
    input wire logic [3:0] fire_net,
    // core state
    input wire drc_pkg::drc_core_out_t app_out,
    input wire drc_pkg::drc_core_out_t net_out,
    // event pulses
    output drc_pkg::drc_core_ev_t app_ev,
    output drc_pkg::drc_core_ev_t net_ev
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        app_ev = 4'h0;
        net_ev = 4'h0;
    end
    // a stopped core cannot request, lock up or let its own watchdog expire
    always @(posedge sys_clk) begin
        app_ev <= fire_app & {4{app_out.run}};
        net_ev <= fire_net & {4{net_out.run}};
    end
endmodule

// ==== verification/drc_top_properties.sv ====
module drc_top_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // indications and events
    input wire drc_pkg::drc_sys_in_t sys_in,
    input wire logic debug_mode,
    input wire drc_pkg::drc_core_ev_t app_ev,
    input wire drc_pkg::drc_core_ev_t net_ev,
    // reset outputs
    input wire drc_pkg::drc_core_out_t app_out,
    input wire drc_pkg::drc_core_out_t net_out,
    input wire logic debug_access_port_rst
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_power_hold: assert property (!sys_in.supply_good [*4] |-> app_out.cpu_rst && !app_out.run)
        else $error("app core not held without supply");
    a_pin_hold: assert property (!sys_in.reset_pin_n [*4] |-> app_out.cpu_rst && net_out.cpu_rst)
        else $error("pin reset not applied to both cores");
    a_brown_hold: assert property (sys_in.brownout_reset [*4] |-> app_out.cpu_rst && net_out.cpu_rst)
        else $error("brownout not applied to both cores");
    a_app_wdog_rst: assert property (app_out.run && app_ev.watchdog_timer |=> app_out.cpu_rst [*4])
        else $error("app watchdog reset pulse wrong");
    a_app_holds_net: assert property (app_out.run && (app_ev.core_sys_reset_request || app_ev.watchdog_timer)
        |=> !net_out.run [*4]) else $error("net core not held after app reset");
    a_net_local: assert property (net_out.run && app_out.run && app_ev == 4'h0 &&
        (net_ev.core_sys_reset_request || net_ev.watchdog_timer) |=> net_out.cpu_rst && app_out.run)
        else $error("net reset not local");
    a_lockup_debug: assert property (debug_mode [*4] ##0 (app_out.run && app_ev.lockup)
        |=> !app_out.cpu_rst [*4]) else $error("lockup reset in debug mode");
    a_dap_debug: assert property (debug_mode [*4] ##0 (!debug_access_port_rst && $rose(sys_in.offwake))
        |=> !debug_access_port_rst [*6]) else $error("debug port reset in debug mode");
    a_net_not_auto: assert property ($fell(app_out.cpu_rst) |-> !net_out.run)
        else $error("net core started with app core");

    c_app_wdog: cover property (app_out.run && app_ev.watchdog_timer);
    c_net_soft: cover property (net_out.run && net_ev.core_sys_reset_request);
    c_offwake_dbg: cover property (debug_mode && $rose(sys_in.offwake));
endmodule

bind drc_top drc_top_properties u_drc_top_properties (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_in(sys_in),
    .debug_mode(debug_mode), .app_ev(app_ev), .net_ev(net_ev), .app_out(app_out), .net_out(net_out),
    .debug_access_port_rst(debug_access_port_rst));

// ==== verification/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    drc_pkg::drc_sys_in_t sys_in = 5'h02;
    logic debug_mode = 1'b0;
    logic [3:0] fire_app = 4'h0;
    logic [3:0] fire_net = 4'h0;
    drc_pkg::drc_core_ev_t app_ev;
    drc_pkg::drc_core_ev_t net_ev;
    drc_pkg::drc_core_out_t app_out;
    drc_pkg::drc_core_out_t net_out;
    logic debug_access_port_rst;
    logic [31:0] rd;
    logic [31:0] acc;
    logic [31:0] nacc;
    logic dap_seen;
    int err_count = 0;
    int cmp_count = 0;
    int cbit[4] = '{drc_pkg::CB_SOFT, drc_pkg::CB_LOCKUP, drc_pkg::CB_WDOG, drc_pkg::CB_DBGSOFT};

    always #50 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    drc_top u_drc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sys_in(sys_in), .debug_mode(debug_mode), .app_ev(app_ev), .net_ev(net_ev),
        .app_out(app_out), .net_out(net_out), .debug_access_port_rst(debug_access_port_rst));
    drc_core_model u_drc_core_model (.sys_clk(sys_clk), .fire_app(fire_app), .fire_net(fire_net),
        .app_out(app_out), .net_out(net_out), .app_ev(app_ev), .net_ev(net_ev));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // single word transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e, s);
    endtask
    task automatic clr();
        ahb(1'b1, drc_pkg::OFS_APP_CAUSE, 32'h0000_01ff);
        ahb(1'b1, drc_pkg::OFS_NET_CAUSE, 32'h0000_01ff);
    endtask
    task automatic fire(input logic c, input logic [3:0] m);
        @(posedge sys_clk);
        if (c)
            fire_net <= m;
        else
            fire_app <= m;
        @(posedge sys_clk);
        fire_app <= 4'h0;
        fire_net <= 4'h0;
    endtask

    initial begin
        #2000000;
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(3);
        sys_in.supply_good <= 1'b1;
        cyc(10);
        chk({31'h0, app_out.cpu_rst}, 32'h1, "held without regulator");
        sys_in.regulator_started <= 1'b1;
        cyc(8);
        chk({30'h0, app_out.run, net_out.run}, 32'h2, "power on run state");
        rdc(drc_pkg::OFS_STATUS, 32'hffff_ffff, 32'h1, "status after power on");
        rdc(drc_pkg::OFS_NET_HOLD, 32'h1, 32'h1, "hold after power on");
        chk({30'h0, hresp, hreadyout}, 32'h1, "bus response okay");
        rdc(drc_pkg::OFS_APP_CAUSE, 32'hffff_ffff, 32'h0, "cause after power on");
        ahb(1'b1, drc_pkg::OFS_NET_HOLD, 32'h0);
        cyc(4);
        rdc(drc_pkg::OFS_STATUS, 32'hffff_ffff, 32'h3, "net released");
        $display("test power_on done");
        for (int c = 1; c >= 0; c--) begin
            clr();
            acc = 32'h0;
            nacc = 32'h0;
            for (int k = 0; k < 4; k++) begin
                fire(c[0], 4'h8 >> k);
                cyc(10);
                acc = acc | (32'h1 << cbit[k]);
                nacc = nacc | (32'h1 << drc_pkg::CB_HOLDOFF) | (k == 2 ? 32'h1 << drc_pkg::CB_APPWDOG : 32'h0);
                chk({30'h0, app_out.run, net_out.run}, c ? 32'h3 : 32'h2, "run after core reset");
                rdc(c ? drc_pkg::OFS_NET_CAUSE : drc_pkg::OFS_APP_CAUSE, 32'h1ff, acc, "own cause");
                rdc(c ? drc_pkg::OFS_APP_CAUSE : drc_pkg::OFS_NET_CAUSE, c ? 32'h1ff : 32'hc0, c ? 32'h0 : nacc,
                    "other cause");
                rdc(drc_pkg::OFS_NET_HOLD, 32'h1, {31'h0, ~c[0]}, "hold after core reset");
                ahb(1'b1, drc_pkg::OFS_NET_HOLD, 32'h0);
            end
            $display("test core_events %0d done", c);
        end
        clr();
        debug_mode <= 1'b1;
        cyc(5);
        fire(1'b0, 4'h4);
        cyc(10);
        chk({31'h0, app_out.run}, 32'h1, "lockup in debug");
        rdc(drc_pkg::OFS_APP_CAUSE, 32'h1ff, 32'h0, "no lockup cause in debug");
        rdc(drc_pkg::OFS_STATUS, 32'h4, 32'h4, "debug status");
        $display("test debug_lockup done");
        for (int d = 1; d >= 0; d--) begin
            debug_mode <= d[0];
            cyc(5);
            sys_in.offwake <= 1'b1;
            dap_seen = 1'b0;
            repeat (12) begin
                cyc(1);
                dap_seen = dap_seen | debug_access_port_rst;
            end
            sys_in.offwake <= 1'b0;
            chk({31'h0, dap_seen}, {31'h0, ~d[0]}, "debug port reset on wake");
            cyc(10);
            chk({30'h0, app_out.run, net_out.run}, 32'h2, "run after wake");
            rdc(drc_pkg::OFS_APP_CAUSE, 32'h10, 32'h10, "wake cause");
            rdc(drc_pkg::OFS_NET_CAUSE, 32'h10, 32'h10, "wake cause net");
            ahb(1'b1, drc_pkg::OFS_NET_HOLD, 32'h0);
            clr();
        end
        $display("test offwake done");
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                sys_in.reset_pin_n <= 1'b0;
            else
                sys_in.brownout_reset <= 1'b1;
            cyc(8);
            chk({30'h0, app_out.cpu_rst, net_out.cpu_rst}, 32'h3, "system reset");
            chk({28'h0, app_out.wdog_rst, app_out.periph_rst, net_out.wdog_rst, net_out.periph_rst}, 32'hf,
                "system reset parts");
            rdc(drc_pkg::OFS_STATUS, 32'hffff_ffff, 32'h8, "status in reset");
            sys_in.reset_pin_n <= 1'b1;
            sys_in.brownout_reset <= 1'b0;
            cyc(8);
            chk({30'h0, app_out.run, net_out.run}, 32'h2, "run after release");
            chk({28'h0, app_out.wdog_rst, app_out.periph_rst, net_out.wdog_rst, net_out.periph_rst}, 32'h3,
                "parts after release");
            acc = k ? 32'h20 : 32'h1;
            rdc(drc_pkg::OFS_APP_CAUSE, 32'h1ff, acc, "system cause");
            rdc(drc_pkg::OFS_NET_CAUSE, acc, acc, "system cause net");
            clr();
        end
        $display("test system_reset done");
        summarize();
    end
endmodule
